/* File: core/tcfv_pkg.sv */
// Package for the Type-C CC swap, pull-down, VCONN and VBUS monitor block.
// Assumes one 100 MHz clock; the CC and VBUS comparator results arrive as raw
// levels and are synchronised inside the block; the VCONN inputs are used unsynchronised.
package tcfv_pkg;
  // Clock rate and derived timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FAST_HZ = 12_000_000;
  localparam int unsigned VBUS_OSC_HZ = 20_000;
  // Fast park sample divider, rounded down
  localparam int unsigned FAST_DIV = CLK_HZ / FAST_HZ;
  // VBUS oscillator period in clocks
  localparam int unsigned VBUS_DIV = CLK_HZ / VBUS_OSC_HZ;
  // Field widths
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DAC_W = 8;
  localparam int unsigned NUM_PIO = 10;
  localparam int unsigned PIO_W = 4;
  localparam int unsigned NUM_VB = 5;
  localparam int unsigned VB_IDX_W = 3;
  localparam logic [VB_IDX_W-1:0] VB_LAST = 3'h4;
  // CC threshold slots in round-robin order
  typedef enum logic [1:0] {
    TCFV_TH_TXOK,
    TCFV_TH_TXNG,
    TCFV_TH_SWAP
  } tcfv_thr_t;
  // Swap detector controls
  typedef struct packed {
    logic detect_en;
    logic [CNT_W-1:0] sample_div;
    logic [CNT_W-1:0] debounce_len;
    logic [DAC_W-1:0] txok_dac;
    logic [DAC_W-1:0] txng_dac;
    logic [DAC_W-1:0] swap_dac;
  } tcfv_det_cfg_t;
  // Swap transmitter controls
  typedef struct packed {
    logic [CNT_W-1:0] tx_len;
    logic [PIO_W-1:0] pin_sel;
    logic cc_sel;
  } tcfv_tx_cfg_t;
endpackage : tcfv_pkg

/* File: core/tcfv_sync.sv */
// Three-stage synchroniser with agreement filter for a pin level.
// Assumes one clock; output changes once stages two and three agree.
`timescale 1ns/10ps
module tcfv_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Asynchronous level and clean result
  input wire logic async_i,
  output logic sync_o
);
  logic s1_ff; // First stage, read only by s2
  logic s2_ff;
  logic s3_ff;
  logic out_ff;
  wire agree = (s2_ff == s3_ff);

  // Chain and filter
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) begin
        out_ff <= s3_ff;
      end
    end
  end
  assign sync_o = out_ff;
endmodule // tcfv_sync

/* File: core/tcfv_swap_tx.sv */
// Swap signalling transmitter for initial source operation.
// Assumes the general-purpose pins are already synchronised.
`timescale 1ns/10ps
module tcfv_swap_tx (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Configuration and triggers
  input wire tcfv_pkg::tcfv_tx_cfg_t cfg_i,
  input wire logic req_set_i,
  input wire logic [tcfv_pkg::NUM_PIO-1:0] pio_i,
  // Status and drive
  output logic req_bit_o,
  output logic active_o,
  output logic [1:0] rsw_en_o
);
  logic req_ff; // Software request bit
  logic pin_q_ff; // Previous selected pin level
  logic act_ff;
  logic sel_ff; // CC latched at start
  logic [tcfv_pkg::CNT_W-1:0] cnt_ff;
  wire sel_pin = pio_i[cfg_i.pin_sel];
  wire pin_rise = sel_pin & ~pin_q_ff;
  wire start = ~act_ff & (req_ff | req_set_i | pin_rise);
  wire done = act_ff & (cnt_ff == '0);

  // Request, pulse timer and latched pin
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_ff <= 1'b0;
      pin_q_ff <= 1'b0;
      act_ff <= 1'b0;
      sel_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      pin_q_ff <= sel_pin;
      if (req_set_i) begin
        req_ff <= 1'b1;
      end else if (done) begin
        req_ff <= 1'b0;
      end
      if (start) begin
        act_ff <= 1'b1;
        sel_ff <= cfg_i.cc_sel;
        cnt_ff <= cfg_i.tx_len;
      end else if (done) begin
        act_ff <= 1'b0;
      end else if (act_ff) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
  assign req_bit_o = req_ff;
  assign active_o = act_ff;
  assign rsw_en_o = act_ff ? (sel_ff ? 2'h2 : 2'h1) : 2'h0;

  // Pull-down lasts length plus one clocks
  swap_len_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    act_ff && cnt_ff != '0 |=> act_ff && cnt_ff == $past(cnt_ff) - 1'b1)
    else $error("swap pull-down ended early");
  req_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $fell(act_ff) |-> !req_ff || $past(req_set_i))
    else $error("request bit not cleared");
endmodule // tcfv_swap_tx

/* File: core/tcfv_top.sv */
// Top of the CC swap, pull-down, VCONN and VBUS monitor block.
// Assumes analog comparators and DAC outside; all controls are plain ports.
`timescale 1ns/10ps
module tcfv_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Swap detection
  input wire tcfv_pkg::tcfv_det_cfg_t det_cfg_i,
  input wire logic cc_cmp_i,
  input wire logic sw_status_clr_i,
  output logic [tcfv_pkg::DAC_W-1:0] cc_dac_o,
  output logic cc_high_bw_o,
  output logic swap_received_status_o,
  output logic [1:0] cc_thr_match_o,
  // Swap transmission
  input wire tcfv_pkg::tcfv_tx_cfg_t tx_cfg_i,
  input wire logic swap_request_set_i,
  input wire logic [tcfv_pkg::NUM_PIO-1:0] general_purpose_pin_i,
  input wire logic mac_tx_en_i,
  output logic swap_request_bit_o,
  output logic [1:0] rsw_en_o,
  output logic mac_tx_en_o,
  // Pull-down control
  input wire logic deadbat_write_i,
  input wire logic [1:0] cc_pd_trim_i,
  output logic deadbat_pulldown_enable_o,
  output logic [1:0] rd_trim_en_o,
  output logic [1:0] deadbat_pulldown_enable_low_o,
  // VCONN
  input wire logic [1:0] vconn_ctl_i,
  input wire logic vconn_oc_i,
  input wire logic [tcfv_pkg::CNT_W-1:0] vconn_oc_time_i,
  input wire logic backdrive_err_i,
  input wire logic discharge_err_i,
  input wire logic auto_off_en_i,
  input wire logic vconn_oc_clr_i,
  output logic [1:0] vconn_en_o,
  output logic vconn_oc_status_o,
  // VBUS monitor
  input wire logic vbus_cmp_i,
  input wire logic [tcfv_pkg::NUM_VB*tcfv_pkg::DAC_W-1:0] vbus_thr_i,
  input wire logic [1:0] pin_ovr_sel_i,
  input wire logic irq_en_i,
  input wire logic vbus_chg_clr_i,
  output logic [tcfv_pkg::DAC_W-1:0] vbus_dac_o,
  output logic [tcfv_pkg::NUM_VB-1:0] flags_a_o,
  output logic cfg_strap_o,
  output logic cfg_strap_valid_o,
  output logic vbus_chg_status_o,
  output logic pin_override_o,
  output logic irq_n_o
);
  // Clean comparator and pin levels
  logic cc_cmp_s;
  logic vbus_cmp_s;
  logic [tcfv_pkg::NUM_PIO-1:0] pio_s;

  tcfv_sync u_cc_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .async_i(cc_cmp_i),
    .sync_o(cc_cmp_s)
  );
  tcfv_sync u_vb_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .async_i(vbus_cmp_i),
    .sync_o(vbus_cmp_s)
  );
  // One synchroniser per pin
  genvar gi;
  generate
    for (gi = 0; gi < tcfv_pkg::NUM_PIO; gi++) begin : g_pio
      tcfv_sync u_pio_sync (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .async_i(general_purpose_pin_i[gi]),
        .sync_o(pio_s[gi])
      );
    end
  endgenerate

  // Swap detector state
  typedef enum logic [1:0] {
    TCFV_IDLE,
    TCFV_CYCLE,
    TCFV_PARK
  } tcfv_det_st_t;
  tcfv_det_st_t st_ff, nxt_st;
  tcfv_pkg::tcfv_thr_t thr_ff, nxt_thr;
  logic [tcfv_pkg::CNT_W-1:0] smp_ff; // Round-robin pacing
  logic [tcfv_pkg::CNT_W-1:0] deb_ff; // Debounce count
  logic [3:0] fast_ff; // 12 MHz pacing
  logic rx_sts_ff;
  logic [1:0] thr_m_ff; // TxOK / TxNG results

  wire en = det_cfg_i.detect_en;
  wire smp_tick = (smp_ff == '0);
  wire fast_tick = (fast_ff == 4'(tcfv_pkg::FAST_DIV - 1));
  wire swap_hit = smp_tick & (thr_ff == tcfv_pkg::TCFV_TH_SWAP) & cc_cmp_s;
  wire deb_done = (deb_ff == '0);
  wire deb_ok = (st_ff == TCFV_PARK) & fast_tick & cc_cmp_s & deb_done;
  wire deb_fail = (st_ff == TCFV_PARK) & fast_tick & ~cc_cmp_s;

  // Threshold after the current one
  function automatic tcfv_pkg::tcfv_thr_t next_thr(
    input tcfv_pkg::tcfv_thr_t t);
    case (t)
      tcfv_pkg::TCFV_TH_TXOK: next_thr = tcfv_pkg::TCFV_TH_TXNG;
      tcfv_pkg::TCFV_TH_TXNG: next_thr = tcfv_pkg::TCFV_TH_SWAP;
      default: next_thr = tcfv_pkg::TCFV_TH_TXOK;
    endcase
  endfunction

  // Detector next state
  always_comb begin
    nxt_st = st_ff;
    nxt_thr = thr_ff;
    case (st_ff)
      // Wait for enable
      TCFV_IDLE: begin
        if (en) begin
          nxt_st = TCFV_CYCLE;
          nxt_thr = tcfv_pkg::TCFV_TH_TXOK;
        end
      end
      TCFV_CYCLE: begin
        if (swap_hit) begin
          nxt_st = TCFV_PARK;
        end else if (smp_tick) begin
          nxt_thr = next_thr(thr_ff);
        end
      end
      TCFV_PARK: begin
        if (deb_ok || deb_fail) begin
          nxt_st = TCFV_CYCLE;
          nxt_thr = tcfv_pkg::TCFV_TH_TXOK;
        end
      end
      default: nxt_st = TCFV_IDLE;
    endcase
    if (!en) begin
      nxt_st = TCFV_IDLE;
      nxt_thr = tcfv_pkg::TCFV_TH_TXOK;
    end
  end

  // Detector registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= TCFV_IDLE;
      thr_ff <= tcfv_pkg::TCFV_TH_TXOK;
    end else begin
      st_ff <= nxt_st;
      thr_ff <= nxt_thr;
    end
  end

  // Pacing and debounce counters
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      smp_ff <= '0;
      fast_ff <= '0;
      deb_ff <= '0;
    end else begin
      if (st_ff != TCFV_CYCLE || smp_tick) begin
        smp_ff <= det_cfg_i.sample_div;
      end else begin
        smp_ff <= smp_ff - 1'b1;
      end
      if (st_ff != TCFV_PARK || fast_tick) begin
        fast_ff <= '0;
      end else begin
        fast_ff <= fast_ff + 4'h1;
      end
      if (st_ff != TCFV_PARK) begin
        deb_ff <= det_cfg_i.debounce_len;
      end else if (fast_tick && !deb_done) begin
        deb_ff <= deb_ff - 1'b1;
      end
    end
  end

  // Status and TxOK/TxNG results
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_sts_ff <= 1'b0;
      thr_m_ff <= 2'h0;
    end else begin
      if (deb_ok) begin
        rx_sts_ff <= 1'b1;
      end else if (sw_status_clr_i) begin
        rx_sts_ff <= 1'b0;
      end
      if (st_ff == TCFV_CYCLE && smp_tick) begin
        if (thr_ff == tcfv_pkg::TCFV_TH_TXOK) begin
          thr_m_ff[0] <= cc_cmp_s;
        end
        if (thr_ff == tcfv_pkg::TCFV_TH_TXNG) begin
          thr_m_ff[1] <= cc_cmp_s;
        end
      end
    end
  end

  assign cc_dac_o =
    (st_ff == TCFV_PARK || thr_ff == tcfv_pkg::TCFV_TH_SWAP) ?
    det_cfg_i.swap_dac :
    (thr_ff == tcfv_pkg::TCFV_TH_TXNG) ? det_cfg_i.txng_dac :
    det_cfg_i.txok_dac;
  assign cc_high_bw_o = en;
  assign swap_received_status_o = rx_sts_ff;
  assign cc_thr_match_o = thr_m_ff;

  // Swap transmitter
  logic tx_active;
  tcfv_swap_tx u_tx (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .cfg_i(tx_cfg_i),
    .req_set_i(swap_request_set_i),
    .pio_i(pio_s),
    .req_bit_o(swap_request_bit_o),
    .active_o(tx_active),
    .rsw_en_o(rsw_en_o)
  );
  assign mac_tx_en_o = mac_tx_en_i & ~tx_active;

  // Pull-down selection
  logic db_ff;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      db_ff <= 1'b1;
    end else if (deadbat_write_i) begin
      db_ff <= ~|cc_pd_trim_i;
    end
  end
  assign deadbat_pulldown_enable_o = db_ff;
  assign rd_trim_en_o = db_ff ? 2'h0 : cc_pd_trim_i;
  assign deadbat_pulldown_enable_low_o = db_ff ? 2'h0 : cc_pd_trim_i;

  // VCONN over-current and shutdown
  logic [tcfv_pkg::CNT_W-1:0] oc_cnt_ff;
  logic oc_sts_ff;
  logic [1:0] vc_off_ff; // Latched forced-off per switch
  wire oc_long = vconn_oc_i & (oc_cnt_ff > vconn_oc_time_i);
  wire err_off = auto_off_en_i & (backdrive_err_i | discharge_err_i);
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oc_cnt_ff <= '0;
      oc_sts_ff <= 1'b0;
      vc_off_ff <= 2'h0;
    end else begin
      if (!vconn_oc_i) begin
        oc_cnt_ff <= '0;
      end else if (!oc_long) begin
        oc_cnt_ff <= oc_cnt_ff + 1'b1;
      end
      if (oc_long) begin
        oc_sts_ff <= 1'b1;
      end else if (vconn_oc_clr_i) begin
        oc_sts_ff <= 1'b0;
      end
      // Switch off, rearm on control low
      if (oc_long || err_off) begin
        vc_off_ff <= vc_off_ff | vconn_ctl_i;
      end else begin
        vc_off_ff <= vc_off_ff & vconn_ctl_i;
      end
    end
  end
  assign vconn_en_o = vconn_ctl_i & ~vc_off_ff;
  assign vconn_oc_status_o = oc_sts_ff;

  // VBUS monitor: strap first, then five thresholds
  logic [15:0] osc_ff;
  logic [tcfv_pkg::VB_IDX_W-1:0] vb_idx_ff;
  logic [tcfv_pkg::NUM_VB-1:0] vb_m_ff;
  logic strap_ff;
  logic strap_v_ff;
  logic chg_ff;
  wire osc_tick = (osc_ff == 16'(tcfv_pkg::VBUS_DIV - 1));
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_ff <= '0;
      vb_idx_ff <= '0;
      vb_m_ff <= '0;
      strap_ff <= 1'b0;
      strap_v_ff <= 1'b0;
      chg_ff <= 1'b0;
    end else begin
      osc_ff <= osc_tick ? 16'h0 : osc_ff + 16'h1;
      if (osc_tick) begin
        if (!strap_v_ff) begin
          strap_ff <= vbus_cmp_s;
          strap_v_ff <= 1'b1;
        end else begin
          vb_m_ff[vb_idx_ff] <= vbus_cmp_s;
          vb_idx_ff <= (vb_idx_ff == tcfv_pkg::VB_LAST) ? '0 :
                       vb_idx_ff + 1'b1;
        end
      end
      if (osc_tick && strap_v_ff && vb_m_ff[vb_idx_ff] != vbus_cmp_s) begin
        chg_ff <= 1'b1;
      end else if (vbus_chg_clr_i) begin
        chg_ff <= 1'b0;
      end
    end
  end
  assign vbus_dac_o = vbus_thr_i[vb_idx_ff*tcfv_pkg::DAC_W +:
                                 tcfv_pkg::DAC_W];
  assign flags_a_o = vb_m_ff;
  assign cfg_strap_o = strap_ff;
  assign cfg_strap_valid_o = strap_v_ff;
  assign vbus_chg_status_o = chg_ff;

  wire vb_any = |vb_m_ff;
  assign pin_override_o = (pin_ovr_sel_i == 2'h1) ? vb_any :
                          (pin_ovr_sel_i == 2'h2) ? (vb_any & rx_sts_ff) :
                          (pin_ovr_sel_i == 2'h3) ? rx_sts_ff : 1'b0;
  assign irq_n_o = ~(rx_sts_ff | oc_sts_ff | (irq_en_i & chg_ff));

  // Park only after a swap hit
  park_entry_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (st_ff == TCFV_CYCLE) ##1 (st_ff == TCFV_PARK) |-> $past(swap_hit))
    else $error("parked without swap match");
  ok_status_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    deb_ok |=> rx_sts_ff && st_ff != TCFV_PARK)
    else $error("swap status missing");
  fail_quiet_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    deb_fail && !rx_sts_ff && !sw_status_clr_i |=> !rx_sts_ff)
    else $error("status set on failed debounce");
  disable_reset_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !en |=> st_ff == TCFV_IDLE)
    else $error("detector not reset on disable");
  mac_block_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    tx_active |-> !mac_tx_en_o)
    else $error("MAC sent during swap");
  oc_off_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    oc_long |=> vconn_en_o == 2'h0 ##0 !irq_n_o)
    else $error("VCONN left on after over-current");
  park_dac_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    st_ff == TCFV_PARK |-> cc_dac_o == det_cfg_i.swap_dac)
    else $error("wrong threshold while parked");
endmodule // tcfv_top

/* File: dv/tcfv_partner.sv */
// Far-side port model: the CC line level and the divided VBUS level.
// Assumes each comparator reads high while the line is above its DAC.
`timescale 1ns/10ps
module tcfv_partner (
  // Levels set by the bench
  input wire logic [7:0] cc_level_i,
  input wire logic [7:0] vbus_level_i,
  // Thresholds from the block
  input wire logic [7:0] cc_dac_i,
  input wire logic [7:0] vbus_dac_i,
  // Raw comparator results
  output logic cc_cmp_o,
  output logic vbus_cmp_o
);
  // VBUS and CC versus their DACs
  // Small analog delay so the block never sees a same-edge change
  assign #2 vbus_cmp_o = vbus_level_i > vbus_dac_i;
  assign #2 cc_cmp_o = cc_level_i > cc_dac_i;
endmodule // tcfv_partner

/* File: dv/tb_tcfv_top.sv */
// Self-checking bench for the CC swap, pull-down, VCONN and VBUS block.
// Assumes the partner model closes both comparator loops.
`timescale 1ns/10ps
module tb_tcfv_top;
  logic clock_i = 0;
  logic nrst_i = 0;
  tcfv_pkg::tcfv_det_cfg_t det;
  tcfv_pkg::tcfv_tx_cfg_t txc;
  logic sw_clr, req_set, mac_in, dbw, oc, be, de, aoff, oc_clr, irq_en, vb_clr;
  logic cc_cmp, vb_cmp, hbw, sts, mac_out, rbit, db_en, ocs, strap;
  logic strap_v, chg, povr, irq_n;
  logic [1:0] trim, vctl, ovr, thr_m, rsw, trim_en, ven, db_low;
  logic [9:0] pins;
  logic [15:0] oc_time;
  logic [39:0] vthr;
  logic [7:0] cc_lvl, vb_lvl, cc_dac, vb_dac, vb_old;
  logic [4:0] flags;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int w;

  tcfv_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .det_cfg_i(det),
    .cc_cmp_i(cc_cmp), .sw_status_clr_i(sw_clr), .cc_dac_o(cc_dac),
    .cc_high_bw_o(hbw), .swap_received_status_o(sts),
    .cc_thr_match_o(thr_m), .tx_cfg_i(txc), .swap_request_set_i(req_set),
    .general_purpose_pin_i(pins), .mac_tx_en_i(mac_in),
    .swap_request_bit_o(rbit), .rsw_en_o(rsw), .mac_tx_en_o(mac_out),
    .deadbat_write_i(dbw), .cc_pd_trim_i(trim),
    .deadbat_pulldown_enable_o(db_en), .rd_trim_en_o(trim_en),
    .deadbat_pulldown_enable_low_o(db_low), .vconn_ctl_i(vctl),
    .vconn_oc_i(oc), .vconn_oc_time_i(oc_time), .backdrive_err_i(be),
    .discharge_err_i(de), .auto_off_en_i(aoff), .vconn_oc_clr_i(oc_clr),
    .vconn_en_o(ven), .vconn_oc_status_o(ocs), .vbus_cmp_i(vb_cmp),
    .vbus_thr_i(vthr), .pin_ovr_sel_i(ovr), .irq_en_i(irq_en),
    .vbus_chg_clr_i(vb_clr), .vbus_dac_o(vb_dac), .flags_a_o(flags),
    .cfg_strap_o(strap), .cfg_strap_valid_o(strap_v),
    .vbus_chg_status_o(chg), .pin_override_o(povr), .irq_n_o(irq_n));
  tcfv_partner partner (.cc_level_i(cc_lvl), .vbus_level_i(vb_lvl),
    .cc_dac_i(cc_dac), .vbus_dac_i(vb_dac), .cc_cmp_o(cc_cmp),
    .vbus_cmp_o(vb_cmp));

  // Free-running 100 MHz clock
  always #5 clock_i = ~clock_i;
  // Hang guard, well above the two VBUS sweeps
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      stop_test();
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // Expected VBUS flags: above each of the five thresholds
  function automatic logic [4:0] vb_model(input int lvl);
    logic [4:0] f;
    for (int i = 0; i < 5; i++) f[i] = lvl > int'(vthr[i*8 +: 8]);
    return f;
  endfunction
  // One swap pulse, started by the request bit or by a pin
  task automatic swap_pulse(input logic by_pin);
    int n;
    int k;
    n = 0;
    k = 0;
    if (by_pin) pins[txc.pin_sel] = 1'b1;
    else req_set = 1'b1;
    cyc(1);
    req_set = 1'b0;
    if (!by_pin) check(rbit, 1);
    // Pin start waits out the synchroniser
    while (rsw === 2'b00 && k < 12) begin
      cyc(1);
      k++;
    end
    while (rsw !== 2'b00 && n < 70000) begin
      check(rsw, txc.cc_sel ? 2'b10 : 2'b01);
      check(mac_out, 0);
      n++;
      cyc(1);
    end
    pins = '0;
    check(n, txc.tx_len + 1);
    check(rbit, 0);
    check(mac_out, 1);
  endtask
  // Follow the threshold slots: order and dwell per slot
  task automatic watch_cycle();
    logic [7:0] prev;
    int dwell;
    int seen;
    prev = cc_dac;
    dwell = 0;
    seen = 0;
    repeat (60) begin
      cyc(1);
      dwell++;
      if (cc_dac !== prev) begin
        check(cc_dac, prev == det.txok_dac ? det.txng_dac :
          prev == det.txng_dac ? det.swap_dac : det.txok_dac);
        if (seen > 0) check(dwell, det.sample_div + 1);
        seen++;
        dwell = 0;
        prev = cc_dac;
      end
    end
    check(seen > 5, 1);
  endtask

  initial begin
    void'($urandom(56404));
    {sw_clr, req_set, mac_in, dbw, oc, be, de, aoff, oc_clr} = '0;
    {irq_en, vb_clr} = '0;
    det = '0;
    txc = '0;
    {trim, vctl, ovr, pins, oc_time} = '0;
    cc_lvl = 8'h30;
    // Thresholds kept off the extremes so a full-scale level matches all
    for (int i = 0; i < 5; i++) vthr[i*8 +: 8] = 8'($urandom_range(16, 240));
    vb_lvl = 8'($urandom);
    cyc(16);
    nrst_i = 1'b1;
    check(db_en, 1);
    check(db_low, 2'b00);
    check(irq_n, 1);
    // Software hands over to the trimmed pull-down in one write
    trim = 2'($urandom_range(1, 3));
    dbw = 1'b1;
    cyc(1);
    dbw = 1'b0;
    check(db_en, 0);
    check(trim_en, trim);
    check(db_low, trim);
    // Back-to-back swaps, both start paths, random length and pin
    mac_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      txc.tx_len = 16'($urandom_range(2, 20));
      txc.pin_sel = 4'($urandom_range(0, 9));
      txc.cc_sel = 1'($urandom);
      swap_pulse(i[0]);
    end
    // Detector: slots cycle with level between TxOK and TxNG
    // Slot must outlast the comparator plus four-cycle synchroniser
    det = '{1'b1, 16'h0007, 16'h0003, 8'h20, 8'h40, 8'h80};
    cyc(20);
    check(hbw, 1);
    watch_cycle();
    check(thr_m, 2'b01);
    cc_lvl = 8'h90;
    w = 0;
    while (sts !== 1'b1 && w < 300) begin
      cyc(1);
      w++;
    end
    check(w >= 32 && w <= 70, 1);
    check(irq_n, 0);
    ovr = 2'b11;
    cyc(1);
    check(povr, 1);
    cc_lvl = 8'h30;
    sw_clr = 1'b1;
    cyc(1);
    sw_clr = 1'b0;
    cyc(30);
    check(sts, 0);
    watch_cycle();
    // Debounce failure and software abort
    det.debounce_len = 16'h00C8;
    cc_lvl = 8'h90;
    cyc(40);
    check(cc_dac, det.swap_dac);
    cc_lvl = 8'h30;
    cyc(20);
    check(sts, 0);
    watch_cycle();
    cc_lvl = 8'h90;
    cyc(40);
    det.detect_en = 1'b0;
    cyc(2);
    check(hbw, 0);
    check(cc_dac, det.txok_dac);
    cc_lvl = 8'h30;
    det.detect_en = 1'b1;
    cyc(10);
    watch_cycle();
    check(sts, 0);
    // VCONN switches, over-current filter, error shutdown
    vctl = 2'b01;
    cyc(2);
    check(ven, 2'b01);
    vctl = 2'b10;
    be = 1'b1;
    cyc(4);
    check(ven, 2'b10);
    be = 1'b0;
    oc_time = 16'h0014;
    oc = 1'b1;
    cyc(10);
    oc = 1'b0;
    cyc(5);
    check(ocs, 0);
    check(ven, 2'b10);
    oc = 1'b1;
    cyc(40);
    oc = 1'b0;
    check(ocs, 1);
    check(ven, 2'b00);
    check(irq_n, 0);
    oc_clr = 1'b1;
    cyc(1);
    oc_clr = 1'b0;
    vctl = 2'b00;
    cyc(2);
    vctl = 2'b01;
    aoff = 1'b1;
    de = 1'b1;
    cyc(4);
    check(ven, 2'b00);
    de = 1'b0;
    // VBUS: let the first full sweep from reset finish
    irq_en = 1'b1;
    ovr = 2'b01;
    cyc(32000);
    check(strap_v, 1);
    w = int'(vb_model(vb_lvl));
    check(strap, w[0]);
    check(flags, vb_model(vb_lvl));
    check(povr, |vb_model(vb_lvl));
    ovr = 2'b10;
    cyc(1);
    check(povr, 0);
    vb_clr = 1'b1;
    cyc(1);
    vb_clr = 1'b0;
    check(chg, 0);
    vb_old = vb_lvl;
    vb_lvl = 8'hFF;
    cyc(32000);
    check(flags, 5'h1F);
    check(chg, vb_model(8'hFF) != vb_model(vb_old));
    check(irq_n, vb_model(8'hFF) == vb_model(vb_old));
    stop_test();
  end
endmodule // tb_tcfv_top
